// File: pigr_pkg.sv
// Shared constants and carrier types for the peripheral interrupt router.
`default_nettype none

package pigr_pkg;

	// Vector space and priority field.
	localparam int          NUM_VEC       = 256;
	localparam int          VEC_W         = 8;
	localparam int          PRIO_W        = 4;
	localparam logic [3:0]  PRIO_OFF      = 4'h0;

	// Source lines from modules on the slow peripheral clock.
	localparam int          NUM_SLOW_SRC  = 32;
	localparam int          SLOW_IDX_W    = 5;
	localparam int          SLOW_SEL_W    = 6;
	// Fixed detection per slow source: a set bit means edge detection.
	localparam logic [31:0] SLOW_EDGE_MASK = 32'h0000_ffff;

	// Source lines from modules on the fast peripheral clock.
	localparam int          NUM_FAST_SRC  = 16;
	localparam int          FAST_IDX_W    = 4;
	localparam int          FAST_SEL_W    = 5;
	// Fixed detection per fast source: a set bit means edge detection.
	localparam logic [15:0] FAST_EDGE_MASK = 16'h00ff;

	// Software configurable vector windows.
	localparam int          SLOW_CFG_FIRST = 128;
	localparam int          SLOW_CFG_LAST  = 207;
	localparam int          FAST_CFG_FIRST = 208;
	localparam int          FAST_CFG_LAST  = 255;
	localparam int          NUM_SLOW_CFG   = SLOW_CFG_LAST - SLOW_CFG_FIRST + 1;
	localparam int          NUM_FAST_CFG   = FAST_CFG_LAST - FAST_CFG_FIRST + 1;
	localparam int          NUM_CFG        = NUM_SLOW_CFG + NUM_FAST_CFG;

	// Group interrupts: 0 slow edge, 1..3 slow level, 4..5 fast level.
	localparam int          NUM_GRP       = 6;
	localparam int          GRP_MEMBERS   = 8;
	localparam int          NUM_GRP_SRC   = NUM_GRP * GRP_MEMBERS;
	localparam logic [5:0]  GRP_EDGE_MASK = 6'h01;
	localparam int          GRP_VEC_BASE  = 110;

	// Values after reset.
	localparam logic [VEC_W-1:0]  RST_VEC   = 8'h00;
	localparam logic [PRIO_W-1:0] RST_LEVEL = 4'h0;

	// Request presented to the CPU core.
	typedef struct packed {
		logic              valid;
		logic [VEC_W-1:0]  vec;
		logic [PRIO_W-1:0] level;
	} pigr_cpu_req_t;

	// Acknowledge returned by the CPU core when it takes a vector.
	typedef struct packed {
		logic             valid;
		logic [VEC_W-1:0] vec;
	} pigr_ack_t;

endpackage : pigr_pkg

`default_nettype wire

// File: pigr_arbiter.sv
// Priority search over all vector requests of the interrupt router.
`default_nettype none

module pigr_arbiter
	import pigr_pkg::*;
(
	input  wire logic [NUM_VEC-1:0]        req,
	input  wire logic [NUM_VEC*PRIO_W-1:0] prio,
	input  wire logic                      skip_en,
	input  wire logic [VEC_W-1:0]          skip_vec,
	output logic                           found,
	output logic [VEC_W-1:0]               best_vec,
	output logic [PRIO_W-1:0]              best_level
);

	// Strict greater-than keeps the lowest vector on equal levels, so ties
	// resolve without extra logic. Level zero never wins: it disables.
	always_comb begin
		found      = 1'b0;
		best_vec   = RST_VEC;
		best_level = PRIO_OFF;
		for (int v = 0; v < NUM_VEC; v++) begin
			if (req[v] && !(skip_en && skip_vec == VEC_W'(v)) &&
			    prio[v*PRIO_W +: PRIO_W] > best_level) begin
				found      = 1'b1;
				best_vec   = VEC_W'(v);
				best_level = prio[v*PRIO_W +: PRIO_W];
			end
		end
	end

endmodule : pigr_arbiter

`default_nettype wire

// File: pigr_router.sv
// Peripheral interrupt grouping and vector routing front end.
`default_nettype none

module pigr_router
	import pigr_pkg::*;
(
	input  wire logic                            clk_sys,
	input  wire logic                            resetn,
	input  wire logic [NUM_SLOW_SRC-1:0]         slow_src,
	input  wire logic [NUM_FAST_SRC-1:0]         fast_src,
	input  wire logic [NUM_GRP_SRC-1:0]          grp_src,
	input  wire logic [NUM_GRP_SRC-1:0]          grp_en,
	input  wire logic [NUM_GRP_SRC-1:0]          grp_clr,
	input  wire logic [NUM_SLOW_CFG*SLOW_SEL_W-1:0] slow_sel,
	input  wire logic [NUM_FAST_CFG*FAST_SEL_W-1:0] fast_sel,
	input  wire logic [NUM_VEC*PRIO_W-1:0]       source_priority_register,
	input  wire logic                            fast_en,
	input  wire logic [VEC_W-1:0]                fast_vec,
	input  wire pigr_ack_t                       cpu_ack,
	output logic [NUM_GRP_SRC-1:0]               grp_pending,
	output logic [NUM_GRP-1:0]                   grp_req,
	output var pigr_cpu_req_t                    cpu_req,
	output logic                                 fast_req
);

	// Previous samples of every source line, used for edge detection.
	logic [NUM_SLOW_SRC-1:0] slow_q_reg;
	logic [NUM_SLOW_SRC-1:0] slow_q_next;
	logic [NUM_FAST_SRC-1:0] fast_q_reg;
	logic [NUM_FAST_SRC-1:0] fast_q_next;
	logic [NUM_GRP_SRC-1:0]  grp_q_reg;
	logic [NUM_GRP_SRC-1:0]  grp_q_next;

	// Member pending flags and the merged group requests.
	logic [NUM_GRP_SRC-1:0]  grp_pend_reg;
	logic [NUM_GRP_SRC-1:0]  grp_pend_next;
	logic [NUM_GRP-1:0]      grp_req_reg;
	logic [NUM_GRP-1:0]      grp_req_next;

	// Pending state of each configurable vector slot.
	logic [NUM_CFG-1:0]      cfg_pend_reg;
	logic [NUM_CFG-1:0]      cfg_pend_next;

	// Per slot view of the source that software routed into it.
	logic [NUM_CFG-1:0]      slot_line;
	logic [NUM_CFG-1:0]      slot_edge;
	logic [NUM_CFG-1:0]      slot_rise;

	// Request vector seen by the arbiter, one bit per vector number.
	logic [NUM_VEC-1:0]      vec_req;

	// Arbiter result and the registered outputs toward the CPU.
	logic                    arb_found;
	logic [VEC_W-1:0]        arb_vec;
	logic [PRIO_W-1:0]       arb_level;
	pigr_cpu_req_t           cpu_req_reg;
	pigr_cpu_req_t           cpu_req_next;
	logic                    fast_req_reg;
	logic                    fast_req_next;

	// Each configurable slot picks one source through its selector. A
	// selector value equal to or beyond the source count leaves the slot unused,
	// which is how software parks a vector without touching its priority.
	genvar k;
	generate
		for (k = 0; k < NUM_CFG; k++) begin : g_slot
			if (k < NUM_SLOW_CFG) begin : g_slow
				// Slow window slot.
				logic [SLOW_SEL_W-1:0] sel;
				logic                  ok;
				logic [SLOW_IDX_W-1:0] idx;
				assign sel = slow_sel[k*SLOW_SEL_W +: SLOW_SEL_W];
				assign ok  = sel < SLOW_SEL_W'(NUM_SLOW_SRC);
				assign idx = sel[SLOW_IDX_W-1:0];
				assign slot_line[k] = ok & slow_src[idx];
				assign slot_edge[k] = ok & SLOW_EDGE_MASK[idx];
				assign slot_rise[k] = ok & slow_src[idx] & ~slow_q_reg[idx];
			end else begin : g_fast
				// Fast window slot.
				logic [FAST_SEL_W-1:0] sel;
				logic                  ok;
				logic [FAST_IDX_W-1:0] idx;
				assign sel = fast_sel[(k-NUM_SLOW_CFG)*FAST_SEL_W +:
				                      FAST_SEL_W];
				assign ok  = sel < FAST_SEL_W'(NUM_FAST_SRC);
				assign idx = sel[FAST_IDX_W-1:0];
				assign slot_line[k] = ok & fast_src[idx];
				assign slot_edge[k] = ok & FAST_EDGE_MASK[idx];
				assign slot_rise[k] = ok & fast_src[idx] & ~fast_q_reg[idx];
			end
		end
	endgenerate

	// Next state of the source samples, group members and group requests.
	always_comb begin
		slow_q_next   = slow_src;
		fast_q_next   = fast_src;
		grp_q_next    = grp_src;
		grp_pend_next = grp_pend_reg;
		grp_req_next  = '0;
		for (int i = 0; i < NUM_GRP_SRC; i++) begin
			if (GRP_EDGE_MASK[i / GRP_MEMBERS]) begin
				// Edge member: sticky, and a new edge beats a clear.
				grp_pend_next[i] = (grp_pend_reg[i] & ~grp_clr[i]) |
				                   (grp_src[i] & ~grp_q_reg[i]);
			end else begin
				// Level member: pending simply follows the line.
				grp_pend_next[i] = grp_src[i];
			end
		end
		// Any enabled pending member holds its group request up.
		for (int g = 0; g < NUM_GRP; g++) begin
			grp_req_next[g] = |(grp_pend_next[g*GRP_MEMBERS +: GRP_MEMBERS]
			    & grp_en[g*GRP_MEMBERS +: GRP_MEMBERS]);
		end
	end

	// Register the sources, members and group requests.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			slow_q_reg   <= '0;
			fast_q_reg   <= '0;
			grp_q_reg    <= '0;
			grp_pend_reg <= '0;
			grp_req_reg  <= '0;
		end else begin
			slow_q_reg   <= slow_q_next;
			fast_q_reg   <= fast_q_next;
			grp_q_reg    <= grp_q_next;
			grp_pend_reg <= grp_pend_next;
			grp_req_reg  <= grp_req_next;
		end
	end

	// Next pending state of each configurable slot. An edge source stays
	// pending until the CPU acknowledges its vector; a fresh edge in the
	// acknowledge cycle survives, so back to back events are not lost.
	always_comb begin
		cfg_pend_next = cfg_pend_reg;
		for (int s = 0; s < NUM_CFG; s++) begin
			if (slot_edge[s]) begin
				cfg_pend_next[s] = (cfg_pend_reg[s] &
				    ~(cpu_ack.valid &&
				      cpu_ack.vec == VEC_W'(SLOW_CFG_FIRST + s))) |
				    slot_rise[s];
			end else begin
				// Level source: the peripheral clears it at its own end.
				cfg_pend_next[s] = slot_line[s];
			end
		end
	end

	// Register the slot pending flags.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cfg_pend_reg <= '0;
		end else begin
			cfg_pend_reg <= cfg_pend_next;
		end
	end

	// Build the full vector request map. Vectors below the configurable
	// windows carry only the group requests here; other fixed sources live
	// outside this block.
	always_comb begin
		vec_req = '0;
		for (int g = 0; g < NUM_GRP; g++) begin
			vec_req[GRP_VEC_BASE + g] = grp_req_reg[g];
		end
		vec_req[NUM_VEC-1:SLOW_CFG_FIRST] = cfg_pend_reg;
	end

	// The fast response vector is taken out of normal arbitration so it is
	// never reported twice; only one vector number can hold this role.
	pigr_arbiter u_arbiter (
		.req        (vec_req),
		.prio       (source_priority_register),
		.skip_en    (fast_en),
		.skip_vec   (fast_vec),
		.found      (arb_found),
		.best_vec   (arb_vec),
		.best_level (arb_level)
	);

	// Next values of the CPU facing request and the fast request line.
	always_comb begin
		cpu_req_next.valid = arb_found;
		cpu_req_next.vec   = arb_vec;
		cpu_req_next.level = arb_level;
		// A fast vector still needs a non-zero level to be enabled.
		fast_req_next = fast_en && vec_req[fast_vec] &&
		    source_priority_register[fast_vec*PRIO_W +: PRIO_W] !=
		    PRIO_OFF;
	end

	// Register the CPU facing outputs so they never glitch.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cpu_req_reg.valid <= 1'b0;
			cpu_req_reg.vec   <= RST_VEC;
			cpu_req_reg.level <= RST_LEVEL;
			fast_req_reg      <= 1'b0;
		end else begin
			cpu_req_reg  <= cpu_req_next;
			fast_req_reg <= fast_req_next;
		end
	end

	// Outputs come straight from flip-flops.
	assign grp_pending = grp_pend_reg;
	assign grp_req     = grp_req_reg;
	assign cpu_req     = cpu_req_reg;
	assign fast_req    = fast_req_reg;

endmodule : pigr_router

`default_nettype wire

// File: pigr_router_asserts.sv
// Checker for the port behaviour of the peripheral interrupt router.
`default_nettype none
module pigr_router_asserts
	import pigr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [NUM_GRP_SRC-1:0] grp_src,
	input wire logic [NUM_GRP_SRC-1:0] grp_en,
	input wire logic [NUM_GRP_SRC-1:0] grp_clr,
	input wire logic fast_en,
	input wire logic [VEC_W-1:0] fast_vec,
	input wire logic [NUM_GRP_SRC-1:0] grp_pending,
	input wire logic [NUM_GRP-1:0] grp_req,
	input wire pigr_cpu_req_t cpu_req,
	input wire logic fast_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Edge member 3 of the slow edge group latches a rising line.
	property p_edge; $rose(grp_src[3]) |=> grp_pending[3]; endproperty
	a_edge: assert property (p_edge) else $error("edge lost");
	property p_hold; grp_pending[3] && !grp_clr[3] |=> grp_pending[3];
	endproperty
	a_hold: assert property (p_hold) else $error("pend lost");
	// A clear wins unless a new edge arrives in the same cycle.
	property p_clr;
		grp_pending[3] && grp_clr[3] && !$rose(grp_src[3]) |=> !grp_pending[3];
	endproperty
	a_clr: assert property (p_clr) else $error("clear ignored");
	property p_lvl; $past(resetn) |-> grp_pending[34] == $past(grp_src[34]);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level lag");
	// Level groups follow the enabled members one cycle late.
	for (genvar g = 1; g < NUM_GRP; g++) begin : g_lvl
		property p_grp; $past(resetn) |->
			grp_req[g] == |$past(grp_src[g*8 +: 8] & grp_en[g*8 +: 8]);
		endproperty
		a_grp: assert property (p_grp) else $error("group req");
	end
	property p_lev; cpu_req.valid |-> cpu_req.level != PRIO_OFF; endproperty
	a_lev: assert property (p_lev) else $error("level zero");
	// Only group vectors and the configurable windows can be requested.
	property p_rng; cpu_req.valid |-> cpu_req.vec >= 8'h80 ||
		(cpu_req.vec >= 8'h6e && cpu_req.vec <= 8'h73); endproperty
	a_rng: assert property (p_rng) else $error("bad vector");
	property p_fast; fast_req |-> $past(fast_en); endproperty
	a_fast: assert property (p_fast) else $error("fast off");
	property p_fexc; cpu_req.valid && $past(fast_en) |->
		cpu_req.vec != $past(fast_vec); endproperty
	a_fexc: assert property (p_fexc) else $error("fast shown");
endmodule : pigr_router_asserts
bind pigr_router pigr_router_asserts i_pigr_router_asserts (.clk_sys,
	.resetn, .grp_src, .grp_en, .grp_clr, .fast_en, .fast_vec,
	.grp_pending, .grp_req, .cpu_req, .fast_req);
`default_nettype wire

// File: pigr_cpu_model.sv
// Behavioural CPU core that takes the vectors the router presents.
`default_nettype none
module pigr_cpu_model
	import pigr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic ack_on,
	input wire logic [1:0] wait_n,
	input wire pigr_cpu_req_t cpu_req,
	input wire logic fast_req,
	input wire logic [VEC_W-1:0] fast_vec,
	output var pigr_ack_t cpu_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt = 2'h0;  // Cycles waited on the present request.
	logic [1:0] hold = 2'h0; // Edges left before looking again.
	// The router needs two edges to retire a taken vector, so the model
	// waits that long; otherwise it would take a stale vector twice.
	always @(posedge clk_sys) begin
		cpu_ack <= '0;
		if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end else if (ack_on && (cpu_req.valid || fast_req)) begin
			if (cnt == wait_n) begin
				cpu_ack <= {1'b1, fast_req ? fast_vec : cpu_req.vec};
				hold <= 2'h2;
				cnt <= 2'h0;
			end else begin
				cnt <= cnt + 2'h1;
			end
		end
	end
endmodule : pigr_cpu_model
`default_nettype wire

// File: pigr_router_tb.sv
// Self-checking bench for the peripheral interrupt router.
`default_nettype none
module pigr_router_tb
	import pigr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [NUM_SLOW_SRC-1:0] slow_src = '0;
	logic [NUM_FAST_SRC-1:0] fast_src = '0;
	logic [NUM_GRP_SRC-1:0] grp_src = '0, grp_en = '1, grp_clr = '0;
	logic [NUM_SLOW_CFG*SLOW_SEL_W-1:0] slow_sel = '1; // All slots parked.
	logic [NUM_FAST_CFG*FAST_SEL_W-1:0] fast_sel = '1;
	logic [NUM_VEC*PRIO_W-1:0] prio = '0;
	logic fast_en = 1'b0, ack_on = 1'b1;
	logic [VEC_W-1:0] fast_vec = '0;
	logic [1:0] wait_n = '0;
	pigr_ack_t cpu_ack;
	logic [NUM_GRP_SRC-1:0] grp_pending;
	logic [NUM_GRP-1:0] grp_req;
	pigr_cpu_req_t cpu_req;
	logic fast_req;
	logic [VEC_W-1:0] q[$]; // Vectors the CPU should take, oldest first.
	int err_count = 0, total_checks = 0, cyc = 0;
	logic [31:0] lfsr = 32'ha4702b38;
	always #5 clk_sys = ~clk_sys;
	pigr_router i_pigr_router (.clk_sys, .resetn, .slow_src, .fast_src,
		.grp_src, .grp_en, .grp_clr, .slow_sel, .fast_sel,
		.source_priority_register(prio), .fast_en, .fast_vec, .cpu_ack,
		.grp_pending, .grp_req, .cpu_req, .fast_req);
	pigr_cpu_model i_pigr_cpu_model (.clk_sys, .ack_on, .wait_n, .cpu_req,
		.fast_req, .fast_vec, .cpu_ack);
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic fail(string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic cmp_bit(logic got, logic exp);
		total_checks++;
		if (got !== exp) fail("flag mismatch");
	endtask : cmp_bit
	task automatic cmp_vec(logic [VEC_W-1:0] got, logic [VEC_W-1:0] exp);
		total_checks++;
		if (got !== exp) fail("vector mismatch");
	endtask : cmp_vec
	task automatic cmp_lvl(logic [PRIO_W-1:0] got, logic [PRIO_W-1:0] exp);
		total_checks++;
		if (got !== exp) fail("level mismatch");
	endtask : cmp_lvl
	task automatic go(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : go
	// Waits for every note to be taken, then a little more for strays.
	task automatic drain();
		for (int n = 0; n < 100 && q.size() != 0; n++) @(posedge clk_sys);
		go(8);
		total_checks++;
		if (q.size() != 0) fail("vector not taken");
	endtask : drain
	task automatic summarize();
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	// Each vector the CPU takes is matched against the oldest note.
	always @(posedge clk_sys) begin
		if (cpu_ack.valid === 1'b1 && q.size() == 0) begin
			fail("stray vector");
		end else if (cpu_ack.valid === 1'b1) begin
			cmp_vec(cpu_ack.vec, q.pop_front());
		end
	end
	always @(posedge clk_sys) if (++cyc > 20000) begin
		fail("timeout");
		summarize();
	end
	initial begin
		logic [31:0] r;
		int k, s, p, v;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		// Random edge source to a random slot; level zero must stay silent.
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			p = r[3:0];
			k = r[10] ? r[31:16] % NUM_FAST_CFG : r[31:16] % NUM_SLOW_CFG;
			s = r[10] ? r[6:4] : r[7:4];
			v = k + (r[10] ? FAST_CFG_FIRST : SLOW_CFG_FIRST);
			@(posedge clk_sys);
			wait_n <= r[9:8];
			if (r[10]) fast_sel[k*FAST_SEL_W +: FAST_SEL_W] <= s[4:0];
			else slow_sel[k*SLOW_SEL_W +: SLOW_SEL_W] <= s[5:0];
			prio[v*PRIO_W +: PRIO_W] <= p[3:0];
			if (p != 0) q.push_back(v[7:0]);
			@(posedge clk_sys);
			if (r[10]) fast_src[s] <= 1'b1;
			else slow_src[s] <= 1'b1;
			@(posedge clk_sys);
			fast_src <= '0;
			slow_src <= '0;
			drain();
			@(posedge clk_sys);
			slow_sel <= '1;
			fast_sel <= '1;
			prio <= '0;
		end
		// Same cycle arrivals: a tie goes to the lower vector, a higher level wins.
		for (int t = 0; t < 2; t++) begin
			@(posedge clk_sys);
			slow_sel[3*SLOW_SEL_W +: SLOW_SEL_W] <= 6'h02;
			slow_sel[9*SLOW_SEL_W +: SLOW_SEL_W] <= 6'h05;
			prio[131*PRIO_W +: PRIO_W] <= 4'h4;
			prio[137*PRIO_W +: PRIO_W] <= t ? 4'h9 : 4'h4;
			q.push_back(t ? 8'h89 : 8'h83);
			q.push_back(t ? 8'h83 : 8'h89);
			@(posedge clk_sys);
			slow_src <= 32'h0000_0024;
			@(posedge clk_sys);
			slow_src <= '0;
			drain();
		end
		// The fast-response vector leaves the vectored request line.
		@(posedge clk_sys);
		fast_sel[2*FAST_SEL_W +: FAST_SEL_W] <= 5'h01;
		prio[210*PRIO_W +: PRIO_W] <= 4'h1;
		fast_en <= 1'b1;
		fast_vec <= 8'hd2;
		ack_on <= 1'b0;
		fast_src[1] <= 1'b1;
		@(posedge clk_sys);
		fast_src[1] <= 1'b0;
		go(3);
		cmp_bit(fast_req, 1'b1);
		cmp_bit(cpu_req.valid, 1'b0);
		@(posedge clk_sys);
		ack_on <= 1'b1;
		q.push_back(8'hd2);
		drain();
		// Groups: the edge member holds until cleared, a disabled one is mute.
		@(posedge clk_sys);
		ack_on <= 1'b0;
		prio[110*PRIO_W +: PRIO_W] <= 4'h2;
		grp_en[9] <= 1'b0;
		grp_src[3] <= 1'b1;
		@(posedge clk_sys);
		grp_src[3] <= 1'b0;
		go(3);
		cmp_bit(grp_pending[3], 1'b1);
		cmp_bit(grp_req[0], 1'b1);
		cmp_vec(cpu_req.vec, 8'h6e);
		cmp_lvl(cpu_req.level, 4'h2);
		@(posedge clk_sys);
		grp_clr[3] <= 1'b1;
		grp_src[9] <= 1'b1;
		@(posedge clk_sys);
		grp_clr[3] <= 1'b0;
		grp_src[34] <= 1'b1;
		go(2);
		cmp_bit(grp_req[0], 1'b0);
		cmp_bit(grp_req[1], 1'b0);
		cmp_bit(grp_req[4], 1'b1);
		// A level source keeps its vector only while its line is high.
		@(posedge clk_sys);
		grp_src <= '0;
		slow_sel[0 +: SLOW_SEL_W] <= 6'h14;
		prio[128*PRIO_W +: PRIO_W] <= 4'h3;
		slow_src[20] <= 1'b1;
		go(4);
		cmp_vec(cpu_req.vec, 8'h80);
		cmp_lvl(cpu_req.level, 4'h3);
		@(posedge clk_sys);
		slow_src[20] <= 1'b0;
		go(3);
		cmp_bit(cpu_req.valid, 1'b0);
		summarize();
	end
endmodule : pigr_router_tb
`default_nettype wire
